// File: logic/nvm_pkg.sv
// Purpose: Shared constants and types for the nonvolatile access register block
// Assumes: AXI4-Lite register bus, 32-bit data, byte-wide registers in the low lane
// Notes:   Every offset and field position of the block lives here, with the byte reset value RST_BYTE
`default_nettype none

package nvm_pkg;
   // ==========================================================
   // Bus geometry
   localparam int          AXI_ADDR_W   = 8;
   localparam int          AXI_DATA_W   = 32;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0]  OFS_DATA_LOW   = 8'h00;
   localparam logic [7:0]  OFS_INDEX_LOW  = 8'h04;
   localparam logic [7:0]  OFS_DATA_HIGH  = 8'h08;
   localparam logic [7:0]  OFS_INDEX_HIGH = 8'h0C;
   localparam logic [7:0]  OFS_CONTROL    = 8'h10;
   localparam logic [7:0]  OFS_UNLOCK     = 8'h14;
   localparam logic [7:0]  OFS_INT_STATUS = 8'h18;
   localparam logic [7:0]  OFS_INT_MASK   = 8'h1C;

   // ==========================================================
   // Field layouts
   localparam int          DATA_HIGH_W    = 6;
   localparam int          INDEX_HIGH_W   = 5;
   localparam int          MEM_ADDR_W     = 13;
   localparam int          MEM_DATA_W     = 14;
   localparam int          CTL_SPACE_BIT  = 7;
   localparam int          CTL_ABORT_BIT  = 3;
   localparam int          CTL_PERMIT_BIT = 2;
   localparam int          CTL_COMMIT_BIT = 1;
   localparam int          CTL_FETCH_BIT  = 0;
   localparam int          INT_W          = 2;
   localparam int          INT_DONE_BIT   = 0;
   localparam int          INT_ABORT_BIT  = 1;

   // ==========================================================
   // Values
   localparam logic [7:0]  UNLOCK_FIRST   = 8'h55;
   localparam logic [7:0]  UNLOCK_SECOND  = 8'hAA;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [23:0] PAD_ZERO       = 24'h000000;

   // ==========================================================
   // State encodings
   typedef enum logic [2:0] {
      NVM_UL_IDLE  = 3'h1,
      NVM_UL_FIRST = 3'h2,
      NVM_UL_ARMED = 3'h4
   } nvm_unlock_state_t;

   typedef enum logic [1:0] {
      NVM_CM_IDLE = 2'h1,
      NVM_CM_BUSY = 2'h2
   } nvm_commit_state_t;
endpackage : nvm_pkg

`default_nettype wire

// File: logic/nvm_unlock.sv
// Purpose: Tracks the two-byte unlock sequence written to the unlock port
// Assumes: wr_fire pulses once per accepted register write
// Notes:   Any write that breaks the sequence drops the arm
`default_nettype none

module nvm_unlock (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // Register write strobe
   input  wire logic       wr_fire,
   input  wire logic       wr_is_unlock,
   input  wire logic [7:0] wr_byte,
   // Sequence state
   output logic            armed
);
   nvm_pkg::nvm_unlock_state_t state_q;

   // ==========================================================
   // Sequence tracker
   // exact byte order
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= nvm_pkg::NVM_UL_IDLE;
      end else if (wr_fire) begin
         if (wr_is_unlock && wr_byte == nvm_pkg::UNLOCK_FIRST) begin
            state_q <= nvm_pkg::NVM_UL_FIRST;
         end else if (wr_is_unlock && state_q == nvm_pkg::NVM_UL_FIRST &&
                      wr_byte == nvm_pkg::UNLOCK_SECOND) begin
            state_q <= nvm_pkg::NVM_UL_ARMED;
         end else begin
            // The arming write is consumed by whatever write follows it
            state_q <= nvm_pkg::NVM_UL_IDLE;
         end
      end
   end

   assign armed = (state_q == nvm_pkg::NVM_UL_ARMED);
endmodule : nvm_unlock

`default_nettype wire

// File: logic/nvm_commit.sv
// Purpose: Write cycle sequencer between start and completion or abort
// Assumes: mem_done comes from the external write timer, abort_evt from reset logic
// Notes:   Abort wins over completion in the same cycle
`default_nettype none

module nvm_commit (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // Control
   input  wire logic start,
   input  wire logic mem_done,
   input  wire logic abort_evt,
   // Status
   output logic      busy,
   output logic      done_pulse,
   output logic      abort_pulse,
   output logic      mem_wr_req
);
   nvm_pkg::nvm_commit_state_t state_q;
   logic                       req_q;

   // ==========================================================
   // Sequencer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= nvm_pkg::NVM_CM_IDLE;
      end else begin
         case (state_q)
            nvm_pkg::NVM_CM_IDLE: begin
               if (start) begin
                  state_q <= nvm_pkg::NVM_CM_BUSY;
               end
            end
            nvm_pkg::NVM_CM_BUSY: begin
               if (abort_evt || mem_done) begin
                  state_q <= nvm_pkg::NVM_CM_IDLE;
               end
            end
            default: begin
               state_q <= nvm_pkg::NVM_CM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_q <= 1'b0;
      end else begin
         req_q <= start && (state_q == nvm_pkg::NVM_CM_IDLE);
      end
   end

   assign busy        = (state_q == nvm_pkg::NVM_CM_BUSY);
   assign abort_pulse = busy && abort_evt;
   assign done_pulse  = busy && mem_done && !abort_evt;
   assign mem_wr_req  = req_q;
endmodule : nvm_commit

`default_nettype wire

// File: logic/nvm_regs.sv
// Purpose: AXI4-Lite register set giving software access to data EEPROM and program flash
// Assumes: Memory array answers a read combinationally while mem_rd_req is high
// Notes:   Only one bus write and one bus read are held at a time
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none

module nvm_regs (
   // Clock and reset
   input  wire logic                               core_clk,
   input  wire logic                               reset_n,
   // AXI4-Lite write address
   input  wire logic [nvm_pkg::AXI_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [nvm_pkg::AXI_DATA_W-1:0]     s_axi_wdata,
   input  wire logic [3:0]                         s_axi_wstrb,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                              s_axi_bresp,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [nvm_pkg::AXI_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   // AXI4-Lite read data
   output logic [nvm_pkg::AXI_DATA_W-1:0]          s_axi_rdata,
   output logic [1:0]                              s_axi_rresp,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready,
   // Memory array port
   output logic [nvm_pkg::MEM_ADDR_W-1:0]          mem_addr,
   output logic                                    mem_space,
   output logic                                    mem_rd_req,
   input  wire logic [nvm_pkg::MEM_DATA_W-1:0]     mem_rd_data,
   output logic [7:0]                              mem_wr_data,
   output logic                                    mem_wr_req,
   input  wire logic                               mem_wr_done,
   // Reset causes that cut a write short
   input  wire logic                               external_reset_pin,
   input  wire logic                               watchdog_reset,
   input  wire logic                               brownout_reset,
   // Interrupt
   output logic                                    irq
);
   // ==========================================================
   // Declarations
   logic [7:0]                      data_low_q;
   logic [7:0]                      index_low_q;
   logic [nvm_pkg::DATA_HIGH_W-1:0] data_high_q;
   logic [nvm_pkg::INDEX_HIGH_W-1:0] index_high_q;
   logic                            space_q;
   logic                            permit_q;
   logic                            abort_q;
   logic                            fetch_q;
   logic [nvm_pkg::INT_W-1:0]       int_st_q;
   logic [nvm_pkg::INT_W-1:0]       int_st_d;
   logic [nvm_pkg::INT_W-1:0]       int_mask_q;
   logic                            aw_held_q;
   logic [7:0]                      awaddr_q;
   logic                            w_held_q;
   logic [7:0]                      wbyte_q;
   logic                            wstrb0_q;
   logic                            bvalid_q;
   logic [1:0]                      bresp_q;
   logic                            rvalid_q;
   logic [1:0]                      rresp_q;
   logic [nvm_pkg::AXI_DATA_W-1:0]  rdata_q;
   logic [7:0]                      rd_addr_q;
   logic [7:0]                      rd_byte;
   logic                            wr_fire;
   logic                            wr_en;
   logic                            ctl_wr;
   logic                            armed;
   logic                            commit_start;
   logic                            busy;
   logic                            done_pulse;
   logic                            abort_pulse;
   logic                            abort_evt;
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == nvm_pkg::OFS_DATA_LOW)   || (a == nvm_pkg::OFS_INDEX_LOW)  ||
                  (a == nvm_pkg::OFS_DATA_HIGH)  || (a == nvm_pkg::OFS_INDEX_HIGH) ||
                  (a == nvm_pkg::OFS_CONTROL)    || (a == nvm_pkg::OFS_UNLOCK)     ||
                  (a == nvm_pkg::OFS_INT_STATUS) || (a == nvm_pkg::OFS_INT_MASK);
   endfunction : is_mapped
   // ==========================================================
   // AXI4-Lite write path
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
   // Lane 0 carries every register; a write without it is answered but ignored
   assign wr_en         = wr_fire && wstrb0_q && is_mapped(awaddr_q);
   assign ctl_wr        = wr_en && (awaddr_q == nvm_pkg::OFS_CONTROL);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= nvm_pkg::RST_BYTE;
         w_held_q  <= 1'b0;
         wbyte_q   <= nvm_pkg::RST_BYTE;
         wstrb0_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= nvm_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(awaddr_q) ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   // ==========================================================
   // AXI4-Lite read path
   assign s_axi_arready = !rvalid_q;
   always_comb begin
      rd_byte = nvm_pkg::RST_BYTE;
      if (s_axi_araddr == nvm_pkg::OFS_DATA_LOW) begin
         rd_byte = data_low_q;
      end else if (s_axi_araddr == nvm_pkg::OFS_INDEX_LOW) begin
         rd_byte = index_low_q;
      end else if (s_axi_araddr == nvm_pkg::OFS_DATA_HIGH) begin
         rd_byte = {2'h0, data_high_q};
      end else if (s_axi_araddr == nvm_pkg::OFS_INDEX_HIGH) begin
         rd_byte = {3'h0, index_high_q};
      end else if (s_axi_araddr == nvm_pkg::OFS_CONTROL) begin
         rd_byte = {space_q, 3'h0, abort_q, permit_q, busy, fetch_q};
      end else if (s_axi_araddr == nvm_pkg::OFS_INT_STATUS) begin
         rd_byte = {6'h00, int_st_q};
      end else if (s_axi_araddr == nvm_pkg::OFS_INT_MASK) begin
         rd_byte = {6'h00, int_mask_q};
      end else begin
         rd_byte = nvm_pkg::RST_BYTE;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_q  <= 1'b0;
         rdata_q   <= {nvm_pkg::PAD_ZERO, nvm_pkg::RST_BYTE};
         rresp_q   <= nvm_pkg::RESP_OKAY;
         rd_addr_q <= nvm_pkg::RST_BYTE;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q  <= 1'b1;
         rdata_q   <= {nvm_pkg::PAD_ZERO, rd_byte};
         rresp_q   <= is_mapped(s_axi_araddr) ? nvm_pkg::RESP_OKAY : nvm_pkg::RESP_SLVERR;
         rd_addr_q <= s_axi_araddr;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
   // ==========================================================
   // Address and data registers
   // low and high data, read capture wins
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_low_q  <= nvm_pkg::RST_BYTE;
         data_high_q <= '0;
      end else if (fetch_q) begin
         data_low_q <= mem_rd_data[7:0];
         if (space_q) begin
            data_high_q <= mem_rd_data[nvm_pkg::MEM_DATA_W-1:8];
         end
      end else if (wr_en && awaddr_q == nvm_pkg::OFS_DATA_LOW) begin
         data_low_q <= wbyte_q;
      end else if (wr_en && awaddr_q == nvm_pkg::OFS_DATA_HIGH) begin
         data_high_q <= wbyte_q[nvm_pkg::DATA_HIGH_W-1:0];
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         index_low_q  <= nvm_pkg::RST_BYTE;
         index_high_q <= '0;
      end else if (wr_en && awaddr_q == nvm_pkg::OFS_INDEX_LOW) begin
         index_low_q <= wbyte_q;
      end else if (wr_en && awaddr_q == nvm_pkg::OFS_INDEX_HIGH) begin
         index_high_q <= wbyte_q[nvm_pkg::INDEX_HIGH_W-1:0];
      end
   end

   // ==========================================================
   // Control register
   // space select, permit
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         space_q  <= 1'b0;
         permit_q <= 1'b0;
      end else if (ctl_wr) begin
         space_q  <= wbyte_q[nvm_pkg::CTL_SPACE_BIT];
         permit_q <= wbyte_q[nvm_pkg::CTL_PERMIT_BIT];
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fetch_q <= 1'b0;
      end else if (fetch_q) begin
         fetch_q <= 1'b0;
      end else if (ctl_wr && wbyte_q[nvm_pkg::CTL_FETCH_BIT]) begin
         fetch_q <= 1'b1;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         abort_q <= 1'b0;
      end else if (abort_pulse) begin
         abort_q <= 1'b1;
      end else if (done_pulse) begin
         abort_q <= 1'b0;
      end else if (ctl_wr) begin
         abort_q <= wbyte_q[nvm_pkg::CTL_ABORT_BIT];
      end
   end
   // start only when armed, permitted and in data space
   assign commit_start = ctl_wr && wbyte_q[nvm_pkg::CTL_COMMIT_BIT] && armed && permit_q &&
                         !wbyte_q[nvm_pkg::CTL_SPACE_BIT] && !busy;
   assign abort_evt    = external_reset_pin || watchdog_reset || brownout_reset;
   nvm_unlock u_unlock (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .wr_fire      (wr_en),
      .wr_is_unlock (awaddr_q == nvm_pkg::OFS_UNLOCK),
      .wr_byte      (wbyte_q),
      .armed        (armed)
   );
   nvm_commit u_commit (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .start       (commit_start),
      .mem_done    (mem_wr_done),
      .abort_evt   (abort_evt),
      .busy        (busy),
      .done_pulse  (done_pulse),
      .abort_pulse (abort_pulse),
      .mem_wr_req  (mem_wr_req)
   );

   // ==========================================================
   // Interrupt status and mask
   // done flag sticky, set beats clear
   always_comb begin
      int_st_d = int_st_q;
      if (wr_en && awaddr_q == nvm_pkg::OFS_INT_STATUS) begin
         int_st_d = int_st_q & ~wbyte_q[nvm_pkg::INT_W-1:0];
      end
      int_st_d[nvm_pkg::INT_DONE_BIT]  = int_st_d[nvm_pkg::INT_DONE_BIT] | done_pulse;
      int_st_d[nvm_pkg::INT_ABORT_BIT] = int_st_d[nvm_pkg::INT_ABORT_BIT] | abort_pulse;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_st_q   <= '0;
         int_mask_q <= '0;
      end else begin
         int_st_q <= int_st_d;
         if (wr_en && awaddr_q == nvm_pkg::OFS_INT_MASK) begin
            int_mask_q <= wbyte_q[nvm_pkg::INT_W-1:0];
         end
      end
   end
   assign irq         = |(int_st_q & int_mask_q);
   assign mem_addr    = {index_high_q, index_low_q};
   assign mem_space   = space_q;
   assign mem_rd_req  = fetch_q;
   assign mem_wr_data = data_low_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   fetch_self_clear_a: assert property (fetch_q |=> !fetch_q)
      else $error("fetch trigger did not clear");
   read_capture_a: assert property (fetch_q |=> data_low_q == $past(mem_rd_data[7:0]))
      else $error("read result not captured");
   data_high_zero_a: assert property (
      (s_axi_rvalid && rd_addr_q == nvm_pkg::OFS_DATA_HIGH) |-> s_axi_rdata[7:6] == 2'h0)
      else $error("data high upper bits not zero");
   index_high_zero_a: assert property (
      (s_axi_rvalid && rd_addr_q == nvm_pkg::OFS_INDEX_HIGH) |-> s_axi_rdata[7:5] == 3'h0)
      else $error("index high upper bits not zero");
   unlock_reads_zero_a: assert property (
      (s_axi_rvalid && rd_addr_q == nvm_pkg::OFS_UNLOCK) |-> s_axi_rdata == '0)
      else $error("unlock port read not zero");
   start_needs_permit_a: assert property ($rose(busy) |-> $past(permit_q))
      else $error("write started without permit");
   start_needs_unlock_a: assert property ($rose(busy) |-> $past(armed) && $past(ctl_wr))
      else $error("write started without unlock");
   program_no_write_a: assert property ($rose(busy) |-> !space_q)
      else $error("write started in program space");
   done_sets_flag_a: assert property (
      done_pulse |=> int_st_q[nvm_pkg::INT_DONE_BIT] && !busy)
      else $error("done flag or commit clear missing");
   abort_sets_flag_a: assert property (abort_pulse |=> abort_q && !busy)
      else $error("abort flag not set");
   write_done_c: cover property (commit_start ##[1:50] done_pulse);
   write_abort_c: cover property (commit_start ##[1:50] abort_pulse);
   program_read_c: cover property (fetch_q && space_q);
endmodule : nvm_regs

`default_nettype wire

// File: bench/nv_memory_access_registers_test.sv
// Purpose: Self-checking bench for the nonvolatile access register block
// Assumes: Bench acts as AXI4-Lite master; array read answered combinationally
// Notes:   Write timer and reset causes are pulsed by the bench
`default_nettype none

module nv_memory_access_registers_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Signals
   logic        core_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, wr_done;
   logic        awready, wready, bvalid, arready, rvalid, mem_space, mem_rd_req, mem_wr_req, irq;
   logic [7:0]  awaddr, araddr, mem_wr_data;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [2:0]  cause;
   logic [12:0] mem_addr;
   logic [13:0] mem_rd_data;
   int          error_cnt, comparisons, wr_req_cnt, rd_req_cnt;
   logic [3:0]  wstrb;
   // Pattern derived from the low address byte only, so a wrong low index byte shows up in the data
   assign mem_rd_data = {mem_addr[5:0], mem_addr[7:0]};

   nvm_regs nvm_regs_i (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .mem_addr(mem_addr), .mem_space(mem_space), .mem_rd_req(mem_rd_req),
      .mem_rd_data(mem_rd_data), .mem_wr_data(mem_wr_data), .mem_wr_req(mem_wr_req),
      .mem_wr_done(wr_done), .external_reset_pin(cause[0]), .watchdog_reset(cause[1]),
      .brownout_reset(cause[2]), .irq(irq));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Strobes last one cycle, so one sample per cycle counts each exactly once
   always @(negedge core_clk) begin
      if (mem_wr_req === 1'b1) wr_req_cnt++;
      if (mem_rd_req === 1'b1) rd_req_cnt++;
   end
   // ==========================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      logic ta, tw, da, dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge core_clk);
      awaddr <= a; wdata <= {24'h000000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(da && dw)) begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge core_clk);
         if (ta) begin awvalid <= 1'b0; da = 1'b1; end
         if (tw) begin wvalid <= 1'b0; dw = 1'b1; end
      end
      do @(negedge core_clk); while (bvalid !== 1'b1);
      check({30'h0, bresp}, {30'h0, er});
      @(posedge core_clk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
      @(posedge core_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(negedge core_clk); while (arready !== 1'b1);
      @(posedge core_clk);
      arvalid <= 1'b0;
      do @(negedge core_clk); while (rvalid !== 1'b1);
      check(rdata, exp);
      check({30'h0, rresp}, {30'h0, er});
      @(posedge core_clk);
      rready <= 1'b0;
   endtask : rd

   task automatic unlock;
      wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_FIRST);
      wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_SECOND);
   endtask : unlock

   task automatic pulse_done;
      @(posedge core_clk) wr_done <= 1'b1;
      @(posedge core_clk) wr_done <= 1'b0;
   endtask : pulse_done

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // ==========================================
   // Tests
   initial begin
      reset_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; wr_done = 1'b0; cause = 3'h0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'hF;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
      rd(8'h20, 32'h0, nvm_pkg::RESP_SLVERR);
      wr(8'h20, 8'h5A, nvm_pkg::RESP_SLVERR);
      $display("test reset_values done");
      wr(nvm_pkg::OFS_DATA_LOW, 8'hA5); rd(nvm_pkg::OFS_DATA_LOW, 32'hA5);
      wr(nvm_pkg::OFS_INDEX_LOW, 8'h12); rd(nvm_pkg::OFS_INDEX_LOW, 32'h12);
      wr(nvm_pkg::OFS_DATA_HIGH, 8'hFF); rd(nvm_pkg::OFS_DATA_HIGH, 32'h3F);
      wr(nvm_pkg::OFS_INDEX_HIGH, 8'hFF); rd(nvm_pkg::OFS_INDEX_HIGH, 32'h1F);
      wr(nvm_pkg::OFS_INDEX_HIGH, 8'h03);
      wstrb <= 4'hE; wr(nvm_pkg::OFS_DATA_LOW, 8'h00);
      wstrb <= 4'hF; rd(nvm_pkg::OFS_DATA_LOW, 32'hA5);
      @(negedge core_clk) check({19'h0, mem_addr}, 32'h0312);
      $display("test field_widths done");
      wr(nvm_pkg::OFS_CONTROL, 8'h01); rd(nvm_pkg::OFS_CONTROL, 32'h0);
      rd(nvm_pkg::OFS_DATA_LOW, 32'h12); rd(nvm_pkg::OFS_DATA_HIGH, 32'h3F);
      wr(nvm_pkg::OFS_DATA_LOW, 8'h77);
      wr(nvm_pkg::OFS_CONTROL, 8'h81); rd(nvm_pkg::OFS_CONTROL, 32'h80);
      @(negedge core_clk) check({31'h0, mem_space}, 32'h1);
      rd(nvm_pkg::OFS_DATA_LOW, 32'h12); rd(nvm_pkg::OFS_DATA_HIGH, 32'h12);
      wr(nvm_pkg::OFS_CONTROL, 8'h84); unlock;
      wr(nvm_pkg::OFS_CONTROL, 8'h86); rd(nvm_pkg::OFS_CONTROL, 32'h84);
      $display("test reads done");
      wr(nvm_pkg::OFS_CONTROL, 8'h00); unlock;
      wr(nvm_pkg::OFS_CONTROL, 8'h06); rd(nvm_pkg::OFS_CONTROL, 32'h04);
      wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_FIRST); wr(nvm_pkg::OFS_DATA_LOW, 8'h3C);
      wr(nvm_pkg::OFS_UNLOCK, nvm_pkg::UNLOCK_SECOND);
      wr(nvm_pkg::OFS_CONTROL, 8'h06); rd(nvm_pkg::OFS_CONTROL, 32'h04);
      unlock;
      wr(nvm_pkg::OFS_CONTROL, 8'h06); rd(nvm_pkg::OFS_CONTROL, 32'h06);
      @(negedge core_clk) check({24'h0, mem_wr_data}, 32'h3C);
      wr(nvm_pkg::OFS_CONTROL, 8'h00); rd(nvm_pkg::OFS_CONTROL, 32'h02);
      pulse_done;
      rd(nvm_pkg::OFS_CONTROL, 32'h00); rd(nvm_pkg::OFS_INT_STATUS, 32'h1);
      @(negedge core_clk) check({31'h0, irq}, 32'h0);
      wr(nvm_pkg::OFS_INT_MASK, 8'h03);
      @(negedge core_clk) check({31'h0, irq}, 32'h1);
      wr(nvm_pkg::OFS_INT_STATUS, 8'h01);
      @(negedge core_clk) check({31'h0, irq}, 32'h0);
      $display("test write_cycle done");
      for (int i = 0; i < 3; i++) begin
         wr(nvm_pkg::OFS_CONTROL, 8'h04); unlock; wr(nvm_pkg::OFS_CONTROL, 8'h06);
         @(posedge core_clk) cause <= 3'(1 << i);
         @(posedge core_clk) cause <= 3'h0;
         rd(nvm_pkg::OFS_CONTROL, 32'h0C); rd(nvm_pkg::OFS_INT_STATUS, 32'h2);
         wr(nvm_pkg::OFS_INT_STATUS, 8'h03);
      end
      // Abort flag kept set on purpose, so the clean completion that follows must clear it
      wr(nvm_pkg::OFS_CONTROL, 8'h0C); unlock; wr(nvm_pkg::OFS_CONTROL, 8'h0E);
      pulse_done;
      rd(nvm_pkg::OFS_CONTROL, 32'h04);
      check(wr_req_cnt, 32'h5);
      check(rd_req_cnt, 32'h2);
      $display("test aborts done");
      give_verdict;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      give_verdict;
   end
endmodule : nv_memory_access_registers_test

`default_nettype wire
